/* hw/bfp_regs.svh */
// Register offsets, field positions, reset values and frame counts
// for the receive backplane frame pulse selector.
// Assumes a 32-bit APB slave with byte addresses; included by bare name.
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH

// Register byte offsets
`define BFP_CFG_OFF 8'h00
`define BFP_STAT_OFF 8'h04

// Configuration register field positions
`define BFP_CFG_ALT_BIT 0
`define BFP_CFG_CRC_BIT 1
`define BFP_CFG_SIG_BIT 2
`define BFP_CFG_OHM_BIT 3
`define BFP_CFG_DIR_BIT 5
`define BFP_CFG_E1_BIT 8
`define BFP_CFG_ESF_BIT 9
`define BFP_CFG_RISE_BIT 10
`define BFP_CFG_SIGEN_BIT 11
`define BFP_CFG_CRCEN_BIT 12
`define BFP_CFG_MASK 32'h0000_1f2f
`define BFP_CFG_RESET 32'h0000_0020

// Status register field positions
`define BFP_STAT_PULSE_BIT 0
`define BFP_STAT_SLAVE_IN_BIT 1
`define BFP_STAT_MASTER_BIT 2
`define BFP_STAT_BIT_LSB 8
`define BFP_STAT_SIG_LSB 16
`define BFP_STAT_CRC_LSB 21
`define BFP_STAT_T1_LSB 26

// Frame geometry, counted from zero
`define BFP_E1_LAST_BIT 8'hff
`define BFP_T1_LAST_BIT 8'hc0
`define BFP_MF_LAST 5'h0f
`define BFP_SF_LAST 5'h0b
`define BFP_ESF_LAST 5'h17
`define BFP_TS0_LAST 8'h07
`define BFP_TS16_FIRST 8'h80
`define BFP_TS16_LAST 8'h87

`endif

/* hw/bfp_pkg.sv */
// Types shared by the receive backplane frame pulse selector.
// Assumes the constants of bfp_regs.svh are included where needed.
package bfp_pkg;

    // Frame position flags from the receive framers, same clock domain
    typedef struct packed {
        logic frame_bit1;   // Next backplane bit is bit 1 of a frame
        logic sig_mf_frame1; // Frame starting now is signaling multiframe frame 1
        logic crc_mf_frame1; // Frame starting now is CRC multiframe frame 1
        logic t1_sf_frame1;  // Frame starting now is T1 superframe frame 1
    } bfp_pos_s;

    // Decoded configuration
    typedef struct packed {
        logic alt_suppress;
        logic crc_sel;
        logic sig_sel;
        logic ohm_sel;
        logic slave_dir;
        logic e1_mode;
        logic t1_esf;
        logic rise_edge;
        logic sig_mf_en;
        logic crc_mf_en;
    } bfp_cfg_s;

    typedef logic [7:0] bfp_bit_t;
    typedef logic [4:0] bfp_frame_t;

endpackage : bfp_pkg

/* hw/bfp_edge_sync.sv */
// Two flip-flop synchroniser with edge pulses for a clock pin.
// Assumes the input is asynchronous to clk and much slower than it.
`timescale 1ns/10ps
module bfp_edge_sync (
    input wire logic clk,      // System clock
    input wire logic rst,      // Synchronous reset, active high
    input wire logic async_in, // Pin level from outside the domain
    output logic level,        // Synchronised level
    output logic rise,         // One-cycle pulse on rising edge
    output logic fall          // One-cycle pulse on falling edge
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule : bfp_edge_sync

/* hw/bfp_frame_pulse.sv */
// Receive backplane frame pulse selector with APB register access.
// Assumes framer position flags arrive on REF_CLK and the backplane
// clock arrives on a pin far slower than REF_CLK.
//
// Functional notes
// R1: Selection bits apply only in master direction
// R2: T1 uses only the signaling selection bit
// R3: T1 signaling select marks superframe first F-bit
// R4: T1 otherwise marks every framing bit
// R5: E1 default marks bit 1 each frame
// R6: E1 CRC select marks CRC multiframe start
// R7: Without CRC framing, still every 16th frame
// R8: E1 signaling select marks signaling multiframe start
// R9: Without signaling framing, still every 16th frame
// R10: Composite rises at signaling, falls after CRC
// R11: Coincident alignments give one-cycle pulse
// R12: Overhead select marks time slots 0, 16
// R13: Direction 0 drives the pulse pin
// R14: Alternate suppression ignored for overhead or input
// R15: Output changes on chosen backplane clock edge
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "bfp_regs.svh"
module bfp_frame_pulse (
    input wire logic REF_CLK,              // System clock, 25 MHz
    input wire logic RESET,                // Synchronous reset, active high
    input wire logic PSEL,                 // APB select
    input wire logic PENABLE,              // APB enable
    input wire logic PWRITE,               // APB direction, high for write
    input wire logic [7:0] PADDR,          // APB byte address
    input wire logic [31:0] PWDATA,        // APB write data
    output logic [31:0] PRDATA,            // APB read data
    output logic PREADY,                   // APB ready
    output logic PSLVERR,                  // APB error on unmapped address
    input wire bfp_pkg::bfp_pos_s FRAMER_POS, // Framer position flags
    input wire logic BACKPLANE_RX_CLOCK,   // Backplane clock pin
    input wire logic BACKPLANE_RX_FRAME_PULSE_I, // Pulse pin input level
    output logic BACKPLANE_RX_FRAME_PULSE_O,     // Pulse pin output level
    output logic BACKPLANE_RX_FRAME_PULSE_OE_N   // Pin enable, low drives
);
    import bfp_pkg::*;

    logic [31:0] cfg_r;
    bfp_cfg_s cfg;
    logic clk_level;
    logic clk_rise;
    logic clk_fall;
    logic step;
    logic slave_level;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic apb_setup;
    logic apb_done;
    logic addr_ok;
    bfp_bit_t bit_r;
    bfp_bit_t bit_nxt;
    bfp_frame_t sig_r;
    bfp_frame_t sig_nxt;
    bfp_frame_t crc_r;
    bfp_frame_t crc_nxt;
    bfp_frame_t t1_r;
    bfp_frame_t t1_nxt;
    logic frame_start;
    logic sig_first;
    logic crc_first;
    logic t1_first;
    logic overhead;
    logic composite;
    logic comp_r;
    logic comp_nxt;
    logic crc_end_r;
    logic alt_odd_r;
    logic cand;
    logic pulse_nxt;
    logic pulse_r;
    logic oe_n_r;
    logic [1:0] settle_r;
    logic settled;

    // Counts up and wraps after the given last value
    function automatic bfp_frame_t frame_inc(input bfp_frame_t v, input bfp_frame_t last);
        frame_inc = (v == last) ? 5'h00 : v + 5'h01;
    endfunction : frame_inc

    function automatic bfp_bit_t bit_inc(input bfp_bit_t v, input bfp_bit_t last);
        bit_inc = (v == last) ? 8'h00 : v + 8'h01;
    endfunction : bit_inc

    // Suppression never applies to composite or overhead marking
    function automatic logic alt_applies(input bfp_cfg_s c);
        alt_applies = !(c.e1_mode && (c.ohm_sel || (c.sig_sel && c.crc_sel)));
    endfunction : alt_applies

    always_comb begin
        cfg.alt_suppress = cfg_r[`BFP_CFG_ALT_BIT];
        cfg.crc_sel = cfg_r[`BFP_CFG_CRC_BIT];
        cfg.sig_sel = cfg_r[`BFP_CFG_SIG_BIT];
        cfg.ohm_sel = cfg_r[`BFP_CFG_OHM_BIT];
        cfg.slave_dir = cfg_r[`BFP_CFG_DIR_BIT];
        cfg.e1_mode = cfg_r[`BFP_CFG_E1_BIT];
        cfg.t1_esf = cfg_r[`BFP_CFG_ESF_BIT];
        cfg.rise_edge = cfg_r[`BFP_CFG_RISE_BIT];
        cfg.sig_mf_en = cfg_r[`BFP_CFG_SIGEN_BIT];
        cfg.crc_mf_en = cfg_r[`BFP_CFG_CRCEN_BIT];
    end

    bfp_edge_sync u_clk_sync (
        .clk(REF_CLK),
        .rst(RESET),
        .async_in(BACKPLANE_RX_CLOCK),
        .level(clk_level),
        .rise(clk_rise),
        .fall(clk_fall)
    );

    // Slave-mode input is only observed, never used for timing
    bfp_edge_sync u_fp_sync (
        .clk(REF_CLK),
        .rst(RESET),
        .async_in(BACKPLANE_RX_FRAME_PULSE_I),
        .level(slave_level),
        .rise(),
        .fall()
    );

    // Edge pulses are false until the synchroniser has filled after reset
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            settle_r <= 2'h0;
        end else if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
        end
    end
    assign settled = (settle_r == 2'h3);

    // R15: chosen edge paces all frame and composite state, and pulse state in master direction
    assign step = settled & (cfg.rise_edge ? clk_rise : clk_fall);

    // APB slave: ready rises in the access phase, one wait-free answer
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_done = PSEL & PENABLE & pready_r;
    assign addr_ok = (PADDR == `BFP_CFG_OFF) || (PADDR == `BFP_STAT_OFF);

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~addr_ok;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            prdata_r <= 32'h0000_0000;
        end else if (apb_setup && !PWRITE) begin
            case (PADDR)
                `BFP_CFG_OFF: begin
                    prdata_r <= cfg_r;
                end
                `BFP_STAT_OFF: begin
                    prdata_r <= 32'h0000_0000;
                    prdata_r[`BFP_STAT_PULSE_BIT] <= pulse_r;
                    prdata_r[`BFP_STAT_SLAVE_IN_BIT] <= slave_level;
                    prdata_r[`BFP_STAT_MASTER_BIT] <= ~cfg.slave_dir;
                    prdata_r[`BFP_STAT_BIT_LSB +: 8] <= bit_r;
                    prdata_r[`BFP_STAT_SIG_LSB +: 5] <= sig_r;
                    prdata_r[`BFP_STAT_CRC_LSB +: 5] <= crc_r;
                    prdata_r[`BFP_STAT_T1_LSB +: 5] <= t1_r;
                end
                default: begin
                    prdata_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Writes land only at the completing access edge
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cfg_r <= `BFP_CFG_RESET;
        end else if (apb_done && PWRITE && PADDR == `BFP_CFG_OFF) begin
            cfg_r <= PWDATA & `BFP_CFG_MASK;
        end
    end

    // Bit and frame position, re-aligned by the framer each frame
    always_comb begin
        if (FRAMER_POS.frame_bit1) begin
            bit_nxt = 8'h00;
        end else begin
            bit_nxt = bit_inc(bit_r, cfg.e1_mode ? `BFP_E1_LAST_BIT : `BFP_T1_LAST_BIT);
        end
        frame_start = (bit_nxt == 8'h00);
        sig_nxt = sig_r;
        crc_nxt = crc_r;
        t1_nxt = t1_r;
        if (frame_start) begin
            // R9: free count keeps every 16th frame
            if (cfg.sig_mf_en && FRAMER_POS.sig_mf_frame1) begin
                sig_nxt = 5'h00;
            end else begin
                sig_nxt = frame_inc(sig_r, `BFP_MF_LAST);
            end
            // R7: free count keeps every 16th frame
            if (cfg.crc_mf_en && FRAMER_POS.crc_mf_frame1) begin
                crc_nxt = 5'h00;
            end else begin
                crc_nxt = frame_inc(crc_r, `BFP_MF_LAST);
            end
            if (FRAMER_POS.t1_sf_frame1) begin
                t1_nxt = 5'h00;
            end else begin
                t1_nxt = frame_inc(t1_r, cfg.t1_esf ? `BFP_ESF_LAST : `BFP_SF_LAST);
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            bit_r <= 8'h00;
            sig_r <= 5'h00;
            crc_r <= 5'h00;
            t1_r <= 5'h00;
        end else if (step) begin
            bit_r <= bit_nxt;
            sig_r <= sig_nxt;
            crc_r <= crc_nxt;
            t1_r <= t1_nxt;
        end
    end

    assign sig_first = frame_start && (sig_nxt == 5'h00);
    assign crc_first = frame_start && (crc_nxt == 5'h00);
    assign t1_first = frame_start && (t1_nxt == 5'h00);

    // R12: time slots 0 and 16 of the frame
    assign overhead = (bit_nxt <= `BFP_TS0_LAST) ||
                      ((bit_nxt >= `BFP_TS16_FIRST) && (bit_nxt <= `BFP_TS16_LAST));

    // R2: overhead and CRC bits do not reach T1 decoding
    assign composite = cfg.e1_mode && !cfg.ohm_sel && cfg.sig_sel && cfg.crc_sel;

    // R10: set at signaling start, clear after the CRC bit 1
    // R11: coincident set and clear leaves one bit period high
    always_comb begin
        if (sig_first) begin
            comp_nxt = 1'b1;
        end else if (crc_end_r) begin
            comp_nxt = 1'b0;
        end else begin
            comp_nxt = comp_r;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            comp_r <= 1'b0;
            crc_end_r <= 1'b0;
        end else if (step) begin
            comp_r <= comp_nxt;
            crc_end_r <= crc_first;
        end
    end

    // Selection of what the pulse marks
    always_comb begin
        cand = 1'b0;
        if (cfg.e1_mode) begin
            if (cfg.ohm_sel) begin
                cand = overhead;
            end else if (composite) begin
                cand = comp_nxt;
            // R6: CRC multiframe frame 1
            end else if (cfg.crc_sel) begin
                cand = crc_first;
            // R8: signaling multiframe frame 1
            end else if (cfg.sig_sel) begin
                cand = sig_first;
            // R5: every frame
            end else begin
                cand = frame_start;
            end
        // R3: superframe first framing bit
        end else if (cfg.sig_sel) begin
            cand = t1_first;
        // R4: every framing bit
        end else begin
            cand = frame_start;
        end
    end

    // R14: suppression only for plain pulse modes in master direction
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            alt_odd_r <= 1'b0;
        end else if (step && cand && alt_applies(cfg)) begin
            alt_odd_r <= ~alt_odd_r;
        end
    end

    always_comb begin
        pulse_nxt = cand;
        if (cfg.alt_suppress && alt_applies(cfg) && alt_odd_r) begin
            pulse_nxt = 1'b0;
        end
        // R1: selections ignored in slave direction
        if (cfg.slave_dir) begin
            pulse_nxt = 1'b0;
        end
    end

    // R15: output moves on the active backplane edge; slave direction clears it on any REF_CLK edge
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pulse_r <= 1'b0;
        end else if (step) begin
            pulse_r <= pulse_nxt;
        end else if (cfg.slave_dir) begin
            pulse_r <= 1'b0;
        end
    end

    // R13: direction 0 enables the pin driver
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= cfg.slave_dir;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign BACKPLANE_RX_FRAME_PULSE_O = pulse_r;
    assign BACKPLANE_RX_FRAME_PULSE_OE_N = oe_n_r;

    // Level not used for status; clk_level unused beyond sync
    logic unused_level;
    assign unused_level = clk_level;
endmodule : bfp_frame_pulse

/* testbench/bfp_frame_pulse_assertions.sv */
// Port checker for the frame pulse selector, bound to its top module.
// Assumes one backplane bit lasts 8 REF_CLK cycles, as in the bench.
`timescale 1ns/10ps
`include "bfp_regs.svh"
module bfp_frame_pulse_assertions (
    input wire logic REF_CLK, // Clock
    input wire logic RESET, // Reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB write
    input wire logic [7:0] PADDR, // APB address
    input wire logic [31:0] PWDATA, // APB data
    input wire logic PREADY, // APB ready
    input wire logic BACKPLANE_RX_CLOCK, // Link clock
    input wire logic BACKPLANE_RX_FRAME_PULSE_O, // Pulse
    input wire logic BACKPLANE_RX_FRAME_PULSE_OE_N // Pin enable
);
    localparam int E1_GAP = 2047;
    localparam int T1_GAP = 1543;
    logic [31:0] cfg_r;
    logic [11:0] age_r, hi_r, gap_r;
    logic [7:0] pin_r;
    logic o_d_r, near;
    wire logic o = BACKPLANE_RX_FRAME_PULSE_O;
    wire logic dir = cfg_r[`BFP_CFG_DIR_BIT];
    wire logic e1 = cfg_r[`BFP_CFG_E1_BIT];
    wire logic comp = e1 && cfg_r[2:1] == 2'h3 && !cfg_r[3];
    wire logic ohm = e1 && cfg_r[3];
    // Shadow of the configuration, age since last write
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cfg_r <= `BFP_CFG_RESET;
            age_r <= 12'h0;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `BFP_CFG_OFF) begin
            cfg_r <= PWDATA & `BFP_CFG_MASK;
            age_r <= 12'h0;
        end else if (age_r != 12'hfff) begin
            age_r <= age_r + 12'h1;
        end
    end
    always_ff @(posedge REF_CLK) begin
        pin_r <= {pin_r[6:0], BACKPLANE_RX_CLOCK};
        o_d_r <= o;
        hi_r <= o ? hi_r + 12'h1 : 12'h0;
        gap_r <= (o && !o_d_r) ? 12'h0 : gap_r + 12'h1;
    end
    // Window wide enough for sync plus edge detect
    always_comb begin
        near = 1'b0;
        for (int i = 0; i < 7; i++) begin
            near = near | ((pin_r[i] ^ pin_r[i + 1]) & (pin_r[i] == cfg_r[`BFP_CFG_RISE_BIT]));
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);
    property p_apb_ready;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("No ready after setup");
    property p_master;
        !dir && age_r > 12'd3 |-> !BACKPLANE_RX_FRAME_PULSE_OE_N;
    endproperty
    a_master: assert property (p_master) else $error("Pin not driven as master");
    property p_slave;
        dir && age_r > 12'd3 |-> BACKPLANE_RX_FRAME_PULSE_OE_N && !o;
    endproperty
    a_slave: assert property (p_slave) else $error("Pulse active as input");
    property p_step;
        $changed(o) && !dir && age_r > 12'd12 |-> near;
    endproperty
    a_step: assert property (p_step) else $error("Pulse moved off a step");
    property p_single;
        $fell(o) && age_r > 12'd2100 && !dir && !comp && !ohm |-> hi_r == 12'd8;
    endproperty
    a_single: assert property (p_single) else $error("Pulse not one bit");
    property p_overhead;
        $fell(o) && age_r > 12'd300 && ohm && !dir |-> hi_r == 12'd64;
    endproperty
    a_overhead: assert property (p_overhead) else $error("Slot mark not 8 bits");
    property p_comp;
        $fell(o) && age_r > 12'd2100 && comp && !dir |-> hi_r == 12'd8 || hi_r == 12'd2056;
    endproperty
    a_comp: assert property (p_comp) else $error("Composite width wrong");
    property p_e1_gap;
        $rose(o) && age_r > 12'd2100 && !dir && e1 && cfg_r[3:0] == 4'h0 |-> gap_r == E1_GAP;
    endproperty
    a_e1_gap: assert property (p_e1_gap) else $error("E1 frame spacing wrong");
    property p_t1_gap;
        $rose(o) && age_r > 12'd2100 && !dir && !e1 && !cfg_r[2] && !cfg_r[0] |-> gap_r == T1_GAP;
    endproperty
    a_t1_gap: assert property (p_t1_gap) else $error("T1 frame spacing wrong");
endmodule : bfp_frame_pulse_assertions

bind bfp_frame_pulse bfp_frame_pulse_assertions i_bfp_frame_pulse_assertions (
    .REF_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .BACKPLANE_RX_CLOCK, .BACKPLANE_RX_FRAME_PULSE_O, .BACKPLANE_RX_FRAME_PULSE_OE_N
);

/* testbench/bfp_backplane_model.sv */
// Backplane side model: link clock, framer position flags, pin wire.
// Assumes the falling link clock edge is the active one.
`timescale 1ns/10ps
module bfp_backplane_model (
    input wire logic ref_clk, // System clock
    input wire logic run, // Let the link clock run
    input wire logic [8:0] len, // Bits per frame
    input wire logic [4:0] sig_per, // Frame-1 spacing, signaling and T1
    input wire logic [4:0] crc_per, // Frame-1 spacing, CRC
    input wire logic [4:0] crc_ph, // CRC frame-1 phase
    input wire logic pulse_o, // Device pulse
    input wire logic pulse_oe_n, // Device pin enable
    output logic bp_clk, // Link clock
    output logic pin_i, // Resolved pin level
    output bfp_pkg::bfp_pos_s pos, // Position of bit shown
    output bfp_pkg::bfp_pos_s prev_pos, // Position of last bit
    output logic [8:0] prev_bit, // Index of last bit
    output logic seen, // Pulse sampled for last bit
    output logic tick // Toggles each step
);
    import bfp_pkg::*;
    logic [8:0] bit_n;
    logic last = 1'b0;
    int frm;
    // Released pin shows the inverse, never a stale level
    always @(posedge ref_clk) begin
        if (!pulse_oe_n) last <= pulse_o;
    end
    assign pin_i = pulse_oe_n ? ~last : pulse_o;
    initial begin
        bp_clk = 1'b1;
        tick = 1'b0;
        bit_n = 9'h1ff;
        frm = -1;
        pos = '0;
        prev_pos = '0;
        prev_bit = 9'h0;
        seen = 1'b0;
        #7;
        forever begin
            #160;
            if (run && bp_clk) begin
                seen = pulse_o;
                prev_pos = pos;
                prev_bit = bit_n;
                bit_n = (bit_n >= len - 9'd1) ? 9'h0 : bit_n + 9'd1;
                if (bit_n == 9'h0) frm = frm + 1;
                pos.frame_bit1 = (bit_n == 9'h0);
                pos.sig_mf_frame1 = (frm % sig_per == 0);
                pos.t1_sf_frame1 = (frm % sig_per == 0);
                pos.crc_mf_frame1 = (frm % crc_per == crc_ph);
                tick = ~tick;
            end
            if (run) bp_clk = ~bp_clk;
        end
    end
endmodule : bfp_backplane_model

/* testbench/bfp_frame_pulse_tb_top.sv */
// Self-checking bench for the receive backplane frame pulse selector.
// Assumes the backplane model supplies link clock and framer flags.
`timescale 1ns/10ps
`include "bfp_regs.svh"
module bfp_frame_pulse_tb_top;
    import bfp_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, run = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, cur_cfg = 32'h20;
    logic pready, pslverr, bp_clk, pin_i, p_o, p_oe_n, seen, tick;
    logic [8:0] len = 9'd256, prev_bit;
    logic [4:0] sig_per = 5'd2, crc_per = 5'd3, crc_ph = 5'd0;
    bfp_pos_s pos, prev_pos;
    int fails = 0, check_count = 0;
    logic comp_st = 1'b0, comp_e = 1'b0;
    bfp_frame_pulse i_bfp_frame_pulse (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .FRAMER_POS(pos), .BACKPLANE_RX_CLOCK(bp_clk),
        .BACKPLANE_RX_FRAME_PULSE_I(pin_i), .BACKPLANE_RX_FRAME_PULSE_O(p_o),
        .BACKPLANE_RX_FRAME_PULSE_OE_N(p_oe_n));
    bfp_backplane_model i_bfp_backplane_model (.ref_clk(ref_clk), .run(run), .len(len),
        .sig_per(sig_per), .crc_per(crc_per), .crc_ph(crc_ph), .pulse_o(p_o),
        .pulse_oe_n(p_oe_n), .bp_clk(bp_clk), .pin_i(pin_i), .pos(pos), .prev_pos(prev_pos),
        .prev_bit(prev_bit), .seen(seen), .tick(tick));
    // Composite level follows the model's flags from reset, across scenarios
    always @(tick) begin
        if (prev_bit == 9'h0 && prev_pos.sig_mf_frame1) comp_st = 1'b1;
        comp_e = comp_st;
        if (prev_bit == 9'h0 && prev_pos.crc_mf_frame1) comp_st = 1'b0;
    end
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        check_count++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            fails++;
            conclude();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr_cfg(input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, `BFP_CFG_OFF, d, q, e);
        cur_cfg = d & `BFP_CFG_MASK;
    endtask : wr_cfg
    task automatic wait_tick();
        logic t;
        int k;
        t = tick;
        k = 0;
        while (tick === t && k < 40) begin
            @(posedge ref_clk);
            k++;
        end
        if (tick === t) begin
            fails++;
            conclude();
        end
    endtask : wait_tick
    // Start on a frame boundary, then judge every bit
    task automatic run_check(input int nf);
        logic e, start;
        int k, n;
        n = cur_cfg[8] ? 256 : 193;
        k = 0;
        wait_tick();
        while (prev_bit != n - 1 && k < 300) begin
            wait_tick();
            k++;
        end
        if (prev_bit != n - 1) begin
            fails++;
            conclude();
        end
        for (k = 0; k < nf * n; k++) begin
            wait_tick();
            start = (prev_bit == 9'h0);
            if (cur_cfg[5]) e = 1'b0;
            else if (!cur_cfg[8]) e = start && (!cur_cfg[2] || prev_pos.t1_sf_frame1);
            else if (cur_cfg[3]) e = prev_bit < 8 || (prev_bit >= 128 && prev_bit < 136);
            else if (cur_cfg[2] && cur_cfg[1]) e = comp_e;
            else if (cur_cfg[2]) e = start && prev_pos.sig_mf_frame1;
            else if (cur_cfg[1]) e = start && prev_pos.crc_mf_frame1;
            else e = start;
            check(seen, e);
            check(p_oe_n, cur_cfg[5]);
        end
    endtask : run_check
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        check(p_oe_n, 1'b1);
        apb(1'b0, `BFP_CFG_OFF, 32'h0, q, e);
        check(q, `BFP_CFG_RESET);
        apb(1'b1, `BFP_CFG_OFF, 32'hffff_ffff, q, e);
        apb(1'b1, 8'h08, 32'h0, q, e);
        check(e, 1'b1);
        apb(1'b0, 8'h08, 32'h0, q, e);
        check({e, q}, {1'b1, 32'h0});
        apb(1'b0, `BFP_CFG_OFF, 32'h0, q, e);
        check(q, `BFP_CFG_MASK);
        $display("Test regs done");
    endtask : t_regs
    task automatic t_e1_default();
        logic [31:0] q;
        logic e;
        wr_cfg(32'h0000_1900);
        run_check(2);
        apb(1'b0, `BFP_CFG_OFF + 8'h04, 32'h0, q, e);
        check(q[`BFP_STAT_MASTER_BIT], 1'b1);
        $display("Test e1_default done");
    endtask : t_e1_default
    task automatic t_mf_select();
        wr_cfg(32'h0000_1902);
        run_check(3);
        wr_cfg(32'h0000_1904);
        run_check(3);
        $display("Test mf_select done");
    endtask : t_mf_select
    task automatic t_composite();
        crc_per <= 5'd2;
        wr_cfg(32'h0000_1906);
        run_check(3);
        sig_per <= 5'd3;
        crc_per <= 5'd3;
        crc_ph <= 5'd1;
        run_check(4);
        $display("Test composite done");
    endtask : t_composite
    task automatic t_overhead();
        wr_cfg(32'h0000_190f);
        run_check(2);
        $display("Test overhead done");
    endtask : t_overhead
    task automatic t_t1();
        len <= 9'd193;
        sig_per <= 5'd2;
        wr_cfg(32'h0000_000a);
        run_check(3);
        wr_cfg(32'h0000_0004);
        run_check(3);
        wr_cfg(32'h0000_0204);
        run_check(3);
        $display("Test t1 done");
    endtask : t_t1
    task automatic t_slave();
        logic [31:0] q;
        logic e;
        len <= 9'd256;
        wr_cfg(32'h0000_192e);
        run_check(1);
        apb(1'b0, `BFP_STAT_OFF, 32'h0, q, e);
        check(q[2:1], {1'b0, pin_i});
        $display("Test slave done");
    endtask : t_slave
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #3600000;
        fails++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        run <= 1'b1;
        t_regs();
        t_e1_default();
        t_mf_select();
        t_composite();
        t_overhead();
        t_t1();
        t_slave();
        conclude();
    end
endmodule : bfp_frame_pulse_tb_top
